// >>> rtl/fcc_top.sv
// Purpose: digital sequencing of a flyback photoflash capacitor charger
// Assumes: single clock, synchronous active-low reset
// Notes: analog sensing arrives as comparator levels
`default_nettype none
module fcc_top
  import fcc_pkg::*;
#(
  parameter int unsigned OFF_CYC = OFF_MAX_CYC
) (
  input wire logic CLK_I, // system clock
  input wire logic RESET_N_I, // sync reset, active low
  input wire logic CHARGE_REQ_I, // host charge request
  input wire logic FIRE_REQUEST_A_I, // fire request a
  input wire logic FIRE_REQUEST_B_I, // fire request b
  input wire logic SUPPLY_LOCKOUT_FLAG_I, // high: supply below lockout
  input wire logic PEAK_LIMIT_PROGRAM_I, // primary current at peak limit
  input wire logic FLUX_RESET_I, // transformer flux reset seen
  input wire logic OUTPUT_SENSE_COMPARE_I, // output at target voltage
  output logic SWITCH_ON_O, // power switch gate
  output logic FLASH_GATE_O, // flash driver drive
  output logic DONE_O, // completion pin output level (always 0)
  output logic DONE_OE_O // completion pull-down enable
);
  initial begin
    if (OFF_CYC < 2 || OFF_CYC > 65535) begin
      $error("OFF_CYC out of range");
    end
  end

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] next_s1, next_s2;
  logic [SYNC_W-1:0] s1, s2;
  fcc_in_s in_q;
  assign raw = {CHARGE_REQ_I, FIRE_REQUEST_A_I, FIRE_REQUEST_B_I,
                SUPPLY_LOCKOUT_FLAG_I, PEAK_LIMIT_PROGRAM_I, FLUX_RESET_I};
  assign in_q = fcc_in_s'(s2);

  always_comb begin
    next_s1 = raw;
    next_s2 = s1;
  end
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
    end
  end

  // target comparator gets its own synchroniser pair
  logic tgt_s1, tgt_s2;
  logic next_tgt_s1, next_tgt_s2;
  always_comb begin
    next_tgt_s1 = OUTPUT_SENSE_COMPARE_I;
    next_tgt_s2 = tgt_s1;
  end
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      tgt_s1 <= 1'b0;
      tgt_s2 <= 1'b0;
    end else begin
      tgt_s1 <= next_tgt_s1;
      tgt_s2 <= next_tgt_s2;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  fcc_state_e state, next_state;
  logic charge_d, next_charge_d;
  logic [15:0] off_cnt, next_off_cnt;
  logic rise;
  localparam logic [15:0] OFF_LAST = 16'(OFF_CYC - 1);

  // rising edge detected in lockout too, but acted on only when supply is fine; a request already high
  // when lockout releases shows no edge, so it waits for a new one
  assign rise = in_q.charge & ~charge_d;

  always_comb begin
    next_state = state;
    next_off_cnt = off_cnt;
    next_charge_d = in_q.charge;
    case (state)
      FCC_STANDBY: begin
        if (rise && !in_q.lockout) begin
          next_state = FCC_ON;
        end
      end
      FCC_ON: begin
        if (tgt_s2) begin
          next_state = FCC_DONE;
        end else if (in_q.peak) begin
          next_state = FCC_OFF;
          next_off_cnt = 16'h0000;
        end
      end
      FCC_OFF: begin
        next_off_cnt = off_cnt + 16'h0001;
        if (tgt_s2) begin
          next_state = FCC_DONE;
        end else if (in_q.flux || off_cnt == OFF_LAST) begin
          next_state = FCC_ON;
        end
      end
      FCC_DONE: begin
        next_state = FCC_DONE;
      end
      default: next_state = FCC_STANDBY;
    endcase
    if (!in_q.charge || in_q.lockout) begin
      next_state = FCC_STANDBY;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      state <= FCC_STANDBY;
      off_cnt <= 16'h0000;
      charge_d <= 1'b1; // no edge right after reset without a low first
    end else begin
      state <= next_state;
      off_cnt <= next_off_cnt;
      charge_d <= next_charge_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic done_q;
  assign done_q = (state == FCC_DONE);
  assign SWITCH_ON_O = (state == FCC_ON) & ~in_q.peak;
  assign DONE_O = 1'b0;
  assign DONE_OE_O = done_q & in_q.charge;
  // gate open when request low or done; blocks noise during charging
  assign FLASH_GATE_O = in_q.fire_a & in_q.fire_b &
                        (~in_q.charge | done_q);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // all checks except AST_SYNC and AST_TGT_SYNC look at the synchronised view, as the sequencer does

  AST_GATE_AND: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    FLASH_GATE_O |-> (in_q.fire_a && in_q.fire_b))
    else $error("gate without both fire requests");

  AST_GATE_LOCK: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (in_q.charge && state != FCC_DONE) |-> !FLASH_GATE_O)
    else $error("gate open during charge");

  AST_START: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (state == FCC_STANDBY && rise && in_q.lockout)
    |=> state == FCC_STANDBY)
    else $error("start while supply below lockout");

  AST_START_EDGE: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (state == FCC_ON && $past(state) == FCC_STANDBY) |->
    ($past(rise) && !$past(in_q.lockout)))
    else $error("start without qualified edge");

  AST_NO_LEVEL: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (state == FCC_STANDBY && !rise) |=> state == FCC_STANDBY)
    else $error("start without edge");

  AST_PEAK_OFF: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    in_q.peak |-> !SWITCH_ON_O)
    else $error("switch on at peak limit");

  AST_SW_STATE: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    SWITCH_ON_O |-> state == FCC_ON)
    else $error("switch on outside on-phase");

  AST_OFF_MAX: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (state == FCC_OFF && off_cnt == OFF_LAST && in_q.charge &&
     !in_q.lockout && !tgt_s2) |=> state == FCC_ON)
    else $error("off-time timeout missed");

  AST_FLUX_ON: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (state == FCC_OFF && in_q.flux && in_q.charge &&
     !in_q.lockout && !tgt_s2) |=> state == FCC_ON)
    else $error("flux reset did not restart");

  AST_OFF_RESTART: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (state == FCC_ON && in_q.peak && in_q.charge &&
     !in_q.lockout && !tgt_s2) |=> (state == FCC_OFF && off_cnt == 16'h0000))
    else $error("off-time count not restarted");

  AST_OFF_BOUND: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    state == FCC_OFF |-> off_cnt <= OFF_LAST)
    else $error("off-time count overran");

  AST_DONE_HOLD: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (state == FCC_DONE && in_q.charge && !in_q.lockout)
    |=> state == FCC_DONE)
    else $error("restart without toggle");

  AST_TGT_STOP: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (tgt_s2 && (state == FCC_ON || state == FCC_OFF) && in_q.charge &&
     !in_q.lockout) |=> state == FCC_DONE)
    else $error("switching went on at target");

  AST_STOP: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    !in_q.charge |=> (state == FCC_STANDBY && !SWITCH_ON_O))
    else $error("charging not stopped");

  AST_LOCKOUT_STOP: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    in_q.lockout |=> state == FCC_STANDBY)
    else $error("charging under lockout");

  AST_DONE_PIN: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    DONE_OE_O == (in_q.charge && state == FCC_DONE))
    else $error("completion pin wrong");

  AST_DONE_LOW: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    DONE_O == 1'b0)
    else $error("completion level not low");

  AST_GATE_TABLE: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (in_q.fire_a && in_q.fire_b && (!in_q.charge || DONE_OE_O))
    |-> FLASH_GATE_O)
    else $error("gate not enabled");

  AST_SYNC: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    s2 == $past(s1))
    else $error("input synchroniser skipped a stage");

  AST_TGT_SYNC: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    tgt_s2 == $past(tgt_s1))
    else $error("target synchroniser skipped a stage");
endmodule
`default_nettype wire

// >>> rtl/fcc_pkg.sv
// Purpose: constants and types for the flash charger control block
// Assumes: 100 MHz system clock
// Notes: one design module, fcc_top
// Notes on behaviour
// - flash gate follows the AND of both fire requests.
// - flash gate is blocked while any charge is still running, not only the first.
// - charging starts only on a charge-request rising edge above lockout.
// - a request already high at lockout release waits for a new edge.
// - switch stays on until peak current limit, then turns off at once.
// - next on-phase at flux reset or 18 us off-time expiry, first wins.
// - at target voltage switching stops until charge request toggles.
// - charge request low stops charging on the next clock, enters standby.
// - completion output pulls low once target voltage is reached.
// - completion output released while charge request is low.
// - gate enabled when request low, or high with completion asserted.
`default_nettype none
package fcc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OFF_MAX_NS = 18_000;
  localparam int unsigned OFF_MAX_CYC =
      (OFF_MAX_NS / 10) * (CLK_HZ / 100_000_000);
  localparam int unsigned SYNC_W = 6;
  localparam logic [1:0] SYNC_RST = 2'h0;

  typedef enum logic [1:0] {
    FCC_STANDBY = 2'b00,
    FCC_ON      = 2'b01,
    FCC_OFF     = 2'b11,
    FCC_DONE    = 2'b10
  } fcc_state_e;

  // synchronised input bundle
  typedef struct packed {
    logic charge;
    logic fire_a;
    logic fire_b;
    logic lockout;
    logic peak;
    logic flux;
  } fcc_in_s;
endpackage
`default_nettype wire

// >>> testbench/fcc_stage_model.sv
// Purpose: power stage model: current ramp and flux reset
// Assumes: the block's gate output is sampled at the clock edge
// Notes: flux reset can be withheld to force the off-time timeout
`default_nettype none
module fcc_stage_model (
  input wire logic clk_i, // system clock
  input wire logic switch_on_i, // switch gate from the block
  input wire logic flux_en_i, // low: never report flux reset
  output var logic peak_o, // primary current at limit
  output var logic flux_o // flux reset seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last = 1'b0;
  int unsigned n = 0;
  initial begin
    peak_o = 1'b0;
    flux_o = 1'b0;
  end
  // current ramps for three cycles, then holds at the limit until turn-off
  always @(posedge clk_i) begin
    last <= switch_on_i;
    n <= (switch_on_i != last) ? 0 : n + 1;
    peak_o <= switch_on_i && switch_on_i == last && n >= 2;
    flux_o <= flux_en_i && !switch_on_i && switch_on_i == last && n >= 2;
  end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Purpose: self-checking bench for the flash charger control block
// Assumes: off-time shortened to 8 cycles
// Notes: the output sense comparator is driven here directly
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OFFC = 8;
  logic clk = 1'b0, rst_n = 1'b0, chg = 1'b0, fa = 1'b0, fb = 1'b1;
  logic lo = 1'b0, tgt = 1'b0, fx_en = 1'b1;
  logic peak, flux, sw, fg, dn, dn_oe;
  int err_count = 0, comparisons = 0, cyc = 0, n = 0;
  initial forever #5 clk = ~clk;
  fcc_top #(.OFF_CYC(OFFC)) u_fcc_top (.CLK_I(clk), .RESET_N_I(rst_n),
    .CHARGE_REQ_I(chg), .FIRE_REQUEST_A_I(fa), .FIRE_REQUEST_B_I(fb),
    .SUPPLY_LOCKOUT_FLAG_I(lo), .PEAK_LIMIT_PROGRAM_I(peak),
    .FLUX_RESET_I(flux), .OUTPUT_SENSE_COMPARE_I(tgt), .SWITCH_ON_O(sw),
    .FLASH_GATE_O(fg), .DONE_O(dn), .DONE_OE_O(dn_oe));
  fcc_stage_model u_fcc_stage_model (.clk_i(clk), .switch_on_i(sw),
    .flux_en_i(fx_en), .peak_o(peak), .flux_o(flux));
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // sample just after the edge so its updates have landed
  task automatic w(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wait_sw(input logic v, input int lim);
    n = 0;
    while (sw !== v && n < lim) begin
      w(1);
      n++;
    end
    chk(sw, v);
  endtask
  task automatic t_lockout();
    @(posedge clk);
    lo <= 1'b1;
    chg <= 1'b1;
    w(10);
    lo <= 1'b0;
    w(20);
    chk(sw, 1'b0);
    chg <= 1'b0;
    w(4);
    chg <= 1'b1;
    wait_sw(1'b1, 6);
  endtask
  task automatic t_cycle();
    fa <= 1'b1;
    wait_sw(1'b0, 10);
    chk(fg, 1'b0);
    wait_sw(1'b1, 20);
    chk(n < OFFC, 1'b1);
    fx_en <= 1'b0;
    wait_sw(1'b0, 10);
    wait_sw(1'b1, 20);
    chk(n >= OFFC && n <= OFFC + 3, 1'b1);
  endtask
  task automatic t_done();
    tgt <= 1'b1;
    w(5);
    chk(dn_oe, 1'b1);
    chk(dn, 1'b0);
    tgt <= 1'b0;
    w(30);
    chk(sw, 1'b0);
    for (int i = 0; i < 4; i++) begin
      fa <= i[0];
      fb <= i[1];
      w(4);
      chk(fg, i[0] & i[1]);
    end
  endtask
  task automatic t_stop();
    chg <= 1'b0;
    w(4);
    chk(dn_oe, 1'b0);
    chk(fg, 1'b1);
    chg <= 1'b1;
    wait_sw(1'b1, 8);
    chk(fg, 1'b0);
    chg <= 1'b0;
    w(20);
    chk(sw, 1'b0);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    w(16);
    rst_n <= 1'b1;
    w(2);
    t_lockout();
    t_cycle();
    t_done();
    t_stop();
    end_sim();
  end
endmodule
`default_nettype wire
